/* File: common/twe_pkg.sv */
`default_nettype none
package twe_pkg;
	// Device address word
	localparam logic [3:0] TWE_DEV_PREFIX = 4'ha;
	// Data word address width per variant, smallest to largest
	localparam int TWE_ADDR_W_MIN = 8;
	localparam int TWE_ADDR_W_MAX = 11;
	localparam int TWE_PAGE_W_SMALL = 3;
	localparam int TWE_PAGE_W_LARGE = 4;
	// Bit slots within one nine-clock word
	localparam logic [3:0] TWE_BIT_FIRST = 4'h1;
	localparam logic [3:0] TWE_BIT_LAST = 4'h7;
	localparam logic [3:0] TWE_BIT_ACK = 4'h8;
	// Erased array content
	localparam logic [7:0] TWE_MEM_RST = 8'hff;
	// Self-timed programming cycle, longest time rounds down
	localparam int TWE_CLK_HZ = 50_000_000;
	localparam int TWE_T_WR_MS = 5;
	localparam int TWE_WR_CYC = TWE_T_WR_MS * (TWE_CLK_HZ / 1000);

	typedef enum logic [2:0] {
		TWE_IDLE,
		TWE_DEV,
		TWE_WADDR,
		TWE_WDATA,
		TWE_RDATA
	} twe_state_t;

	typedef struct packed {
		logic chip_select_pin_high;
		logic chip_select_pin_mid;
		logic chip_select_pin_low;
	} twe_sel_t;
endpackage
`default_nettype wire

/* File: src/twe_target.sv */
`timescale 1ns/10ps
`default_nettype none

module twe_target #(
	parameter int ADDR_W = twe_pkg::TWE_ADDR_W_MIN,
	parameter int WR_CYC = twe_pkg::TWE_WR_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scl_clk,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire twe_pkg::twe_sel_t chip_select,
	input wire logic write_protect,
	output logic standby,
	output logic busy
);
	localparam int PAGE_W = (ADDR_W == twe_pkg::TWE_ADDR_W_MIN) ?
		twe_pkg::TWE_PAGE_W_SMALL : twe_pkg::TWE_PAGE_W_LARGE;
	localparam int PG_N = 1 << PAGE_W;
	localparam int MEM_N = 1 << ADDR_W;
	localparam int TMR_W = $clog2(WR_CYC);
	// Select positions that still compare against pins
	localparam logic [2:0] SEL_MASK = 3'(3'b111 << (ADDR_W - twe_pkg::TWE_ADDR_W_MIN));

	if (ADDR_W < twe_pkg::TWE_ADDR_W_MIN || ADDR_W > twe_pkg::TWE_ADDR_W_MAX ||
		WR_CYC < 2) begin : g_bad_param
		$error("twe_target: unsupported ADDR_W or WR_CYC");
	end

	// Edge events on the data line, clocked by the data line itself
	logic start_tgl_q;
	logic stop_tgl_q;

	// Link domain
	twe_pkg::twe_state_t st_q;
	logic [3:0] cnt_q;
	logic [6:0] sh_q;
	logic ack_q;
	logic [ADDR_W-1:0] addr_q;
	logic [2:0] dev_pg_q;
	logic [7:0] tx_q;
	logic [7:0] pbuf_q [PG_N];
	logic [PG_N-1:0] pmask_q;
	logic wr_tgl_q;
	logic start_smp_q;
	logic stop_smp_q;
	logic start_seen_q;
	logic stop_seen_q;
	twe_pkg::twe_sel_t sel_m_q;
	twe_pkg::twe_sel_t sel_s_q;
	logic busy_m_q;
	logic busy_s_q;

	// System domain
	logic stp_m_q, stp_s_q, stp_d_q;
	logic sta_m_q, sta_s_q, sta_d_q;
	logic wrt_m_q, wrt_s_q;
	logic wp_m_q, wp_s_q;
	logic done_q;
	logic [TMR_W-1:0] tmr_q;
	logic [7:0] mem_q [MEM_N];

	logic new_start;
	logic new_stop;
	logic [7:0] rx_byte;
	logic dev_ok;
	logic stop_ev;
	logic start_ev;
	logic prog_go;

	assign new_start = start_smp_q ^ start_seen_q;
	assign new_stop = stop_smp_q ^ stop_seen_q;
	assign rx_byte = {sh_q, sda_i};
	assign dev_ok = rx_byte[7:4] == twe_pkg::TWE_DEV_PREFIX &&
		((rx_byte[3:1] ^ sel_s_q) & SEL_MASK) == 3'h0 &&
		!busy_s_q;

	// Start and stop seen as data edges while the clock stands high
	always_ff @(negedge sda_i or posedge rst) begin
		if (rst) begin
			start_tgl_q <= 1'b0;
		end else if (scl_clk) begin
			start_tgl_q <= !start_tgl_q;
		end
	end

	always_ff @(posedge sda_i or posedge rst) begin
		if (rst) begin
			stop_tgl_q <= 1'b0;
		end else if (scl_clk) begin
			stop_tgl_q <= !stop_tgl_q;
		end
	end

	// Straps and busy into the link domain
	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			sel_m_q <= '0;
			sel_s_q <= '0;
			busy_m_q <= 1'b0;
			busy_s_q <= 1'b0;
		end else begin
			sel_m_q <= chip_select;
			sel_s_q <= sel_m_q;
			busy_m_q <= busy;
			busy_s_q <= busy_m_q;
		end
	end

	// Falling edge: catch line events a half clock before use, drive the line
	always_ff @(negedge scl_clk or posedge rst) begin
		if (rst) begin
			start_smp_q <= 1'b0;
			stop_smp_q <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			start_smp_q <= start_tgl_q;
			stop_smp_q <= stop_tgl_q;
			if (cnt_q == twe_pkg::TWE_BIT_ACK) begin
				sda_oe <= ack_q;
			end else if (st_q == twe_pkg::TWE_RDATA) begin
				sda_oe <= !tx_q[3'(twe_pkg::TWE_BIT_LAST - cnt_q)];
			end else begin
				sda_oe <= 1'b0;
			end
		end
	end

	// Rising edge: protocol engine. The array is read across domains; it only
	// changes while busy, and then every address word is refused.
	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			st_q <= twe_pkg::TWE_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 7'h00;
			ack_q <= 1'b0;
			addr_q <= '0;
			dev_pg_q <= 3'h0;
			tx_q <= 8'h00;
			pmask_q <= '0;
			wr_tgl_q <= 1'b0;
			start_seen_q <= 1'b0;
			stop_seen_q <= 1'b0;
			for (int i = 0; i < PG_N; i++) begin
				pbuf_q[i] <= 8'h00;
			end
		end else if (new_start) begin
			start_seen_q <= start_smp_q;
			stop_seen_q <= stop_smp_q;
			st_q <= twe_pkg::TWE_DEV;
			sh_q <= {6'h00, sda_i};
			cnt_q <= twe_pkg::TWE_BIT_FIRST;
			ack_q <= 1'b0;
		end else if (new_stop) begin
			stop_seen_q <= stop_smp_q;
			st_q <= twe_pkg::TWE_IDLE;
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
		end else if (st_q != twe_pkg::TWE_IDLE) begin
			if (cnt_q == twe_pkg::TWE_BIT_ACK) begin
				cnt_q <= 4'h0;
				ack_q <= 1'b0;
				if (st_q == twe_pkg::TWE_RDATA && !ack_q) begin
					if (sda_i) begin
						st_q <= twe_pkg::TWE_IDLE;
					end else begin
						tx_q <= mem_q[addr_q];
					end
				end
			end else begin
				cnt_q <= cnt_q + 4'h1;
				sh_q <= {sh_q[5:0], sda_i};
				if (cnt_q == twe_pkg::TWE_BIT_LAST) begin
					ack_q <= 1'b1;
					unique case (st_q)
						twe_pkg::TWE_DEV: begin
							if (!dev_ok) begin
								st_q <= twe_pkg::TWE_IDLE;
								ack_q <= 1'b0;
							end else if (rx_byte[0]) begin
								st_q <= twe_pkg::TWE_RDATA;
								tx_q <= mem_q[addr_q];
							end else begin
								st_q <= twe_pkg::TWE_WADDR;
								dev_pg_q <= rx_byte[3:1];
							end
						end
						twe_pkg::TWE_WADDR: begin
							// Page bits land above the word address
							addr_q <= ADDR_W'({dev_pg_q, rx_byte});
							pmask_q <= '0;
							st_q <= twe_pkg::TWE_WDATA;
						end
						twe_pkg::TWE_WDATA: begin
							pbuf_q[addr_q[PAGE_W-1:0]] <= rx_byte;
							pmask_q[addr_q[PAGE_W-1:0]] <= 1'b1;
							if (pmask_q == '0) begin
								wr_tgl_q <= !wr_tgl_q;
							end
							addr_q <= {addr_q[ADDR_W-1:PAGE_W],
								addr_q[PAGE_W-1:0] + 1'b1};
						end
						twe_pkg::TWE_RDATA: begin
							ack_q <= 1'b0;
							addr_q <= addr_q + 1'b1;
						end
						twe_pkg::TWE_IDLE: ;
					endcase
				end
			end
		end
	end

	// Link events and write protect into the system domain
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stp_m_q <= 1'b0;
			stp_s_q <= 1'b0;
			stp_d_q <= 1'b0;
			sta_m_q <= 1'b0;
			sta_s_q <= 1'b0;
			sta_d_q <= 1'b0;
			wrt_m_q <= 1'b0;
			wrt_s_q <= 1'b0;
			wp_m_q <= 1'b0;
			wp_s_q <= 1'b0;
		end else begin
			stp_m_q <= stop_tgl_q;
			stp_s_q <= stp_m_q;
			stp_d_q <= stp_s_q;
			sta_m_q <= start_tgl_q;
			sta_s_q <= sta_m_q;
			sta_d_q <= sta_s_q;
			wrt_m_q <= wr_tgl_q;
			wrt_s_q <= wrt_m_q;
			wp_m_q <= write_protect;
			wp_s_q <= wp_m_q;
		end
	end

	assign stop_ev = stp_s_q ^ stp_d_q;
	assign start_ev = sta_s_q ^ sta_d_q;
	assign prog_go = !busy && stop_ev && wrt_s_q != done_q && !wp_s_q;

	// Programming timer and standby
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sda_o <= 1'b0;
			done_q <= 1'b0;
			busy <= 1'b0;
			tmr_q <= '0;
			standby <= 1'b1;
		end else begin
			sda_o <= 1'b0;
			if (busy) begin
				if (tmr_q == '0) begin
					busy <= 1'b0;
					standby <= 1'b1;
				end else begin
					tmr_q <= tmr_q - 1'b1;
				end
			end else if (stop_ev) begin
				done_q <= wrt_s_q;
				standby <= !prog_go;
				if (prog_go) begin
					busy <= 1'b1;
					tmr_q <= TMR_W'(WR_CYC - 1);
				end
			end else if (start_ev) begin
				standby <= 1'b0;
			end
		end
	end

	// Page buffer and address stand still after stop, so they are copied here
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < MEM_N; i++) begin
				mem_q[i] <= twe_pkg::TWE_MEM_RST;
			end
		end else if (prog_go) begin
			for (int i = 0; i < PG_N; i++) begin
				if (pmask_q[i]) begin
					mem_q[{addr_q[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pbuf_q[i];
				end
			end
		end
	end

	sequence ack_slot_s;
		cnt_q == twe_pkg::TWE_BIT_ACK && ack_q ##1 cnt_q == 4'h0;
	endsequence
	sequence wbyte_end_s;
		(st_q == twe_pkg::TWE_WADDR || st_q == twe_pkg::TWE_WDATA) &&
			cnt_q == twe_pkg::TWE_BIT_LAST && !new_start && !new_stop;
	endsequence

	drive_low_only_a: assert property (@(posedge clk_sys) disable iff (rst)
		!$rose(sda_o))
		else $error("data line driven high");
	oe_steady_high_a: assert property (@(posedge clk_sys) disable iff (rst)
		scl_clk && $past(scl_clk) && $past(scl_clk, 2) |-> $stable(sda_oe))
		else $error("data output moved while clock high");
	wp_blocks_prog_a: assert property (@(posedge clk_sys) disable iff (rst)
		stop_ev && wp_s_q && !busy |=> !busy ##1 !busy)
		else $error("programming ran under write protect");
	start_restart_a: assert property (@(posedge scl_clk) disable iff (rst)
		new_start |=> st_q == twe_pkg::TWE_DEV && cnt_q == twe_pkg::TWE_BIT_FIRST)
		else $error("start did not restart decoding");
	byte_acked_a: assert property (@(posedge scl_clk) disable iff (rst)
		wbyte_end_s |=> ack_slot_s)
		else $error("received byte not acknowledged");
	dev_refused_a: assert property (@(posedge scl_clk) disable iff (rst)
		st_q == twe_pkg::TWE_DEV && cnt_q == twe_pkg::TWE_BIT_LAST && !new_start &&
		!new_stop && !dev_ok |=> st_q == twe_pkg::TWE_IDLE && !ack_q)
		else $error("address word wrongly acknowledged");
	busy_nack_a: assert property (@(posedge scl_clk) disable iff (rst)
		st_q == twe_pkg::TWE_DEV && busy_s_q |=> !ack_q)
		else $error("acknowledge while programming");
	prog_len_a: assert property (@(posedge clk_sys) disable iff (rst)
		prog_go |=> busy && tmr_q == TMR_W'(WR_CYC - 1))
		else $error("programming cycle length wrong");
	page_wrap_a: assert property (@(posedge scl_clk) disable iff (rst)
		st_q == twe_pkg::TWE_WDATA && cnt_q == twe_pkg::TWE_BIT_LAST && !new_start &&
		!new_stop |=> addr_q[ADDR_W-1:PAGE_W] == $past(addr_q[ADDR_W-1:PAGE_W]) &&
		addr_q[PAGE_W-1:0] == $past(addr_q[PAGE_W-1:0]) + 1'b1)
		else $error("page write address left its page");
	read_adv_a: assert property (@(posedge scl_clk) disable iff (rst)
		st_q == twe_pkg::TWE_RDATA && cnt_q == twe_pkg::TWE_BIT_LAST && !new_start &&
		!new_stop |=> addr_q == $past(addr_q) + 1'b1 && !ack_q)
		else $error("read address did not advance");
	stop_standby_a: assert property (@(posedge clk_sys) disable iff (rst)
		stop_ev && !busy && !prog_go |=> standby)
		else $error("no standby after stop");
endmodule

`default_nettype wire

/* File: tb/twe_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module twe_host_model (
	output logic scl_clk,
	output logic sda_pull,
	input wire logic sda_i
);
	// Clock rests high between frames, data released to the pull-up
	initial begin
		scl_clk = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic bit_x(input logic b, output logic s);
		sda_pull = !b;
		#20 scl_clk = 1'b1;
		#20 s = sda_i;
		#20 scl_clk = 1'b0;
		#20;
	endtask
	task automatic start();
		sda_pull = 1'b0;
		#20 scl_clk = 1'b1;
		#20 sda_pull = 1'b1;
		#20 scl_clk = 1'b0;
		#20;
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		#20 scl_clk = 1'b1;
		#20 sda_pull = 1'b0;
		#40;
	endtask
	// Ninth bit is sent as given; released for a target acknowledge
	task automatic xfer(input logic [7:0] tx, input logic ninth, output logic [7:0] rx,
		output logic nine);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], s);
			rx[i] = s;
		end
		bit_x(ninth, nine);
	endtask
	task automatic recover(output logic stuck);
		logic s;
		stuck = 1'b1;
		for (int i = 0; i < 9 && stuck; i++) begin
			bit_x(1'b1, s);
			stuck = !s;
		end
		start();
	endtask
endmodule
`default_nettype wire

/* File: tb/two_wire_eeprom_target_if_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module two_wire_eeprom_target_if_tb_top;
	localparam int WR_CYC = 100;
	localparam logic [2:0] SEL = 3'h5;
	logic clk_sys, rst, scl_clk, sda_pull, sda_o, sda_oe, write_protect, standby, busy;
	twe_pkg::twe_sel_t chip_select;
	wire logic sda_wire;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	int busy_run = 0;
	int busy_len = 0;
	assign sda_wire = !((sda_oe && !sda_o) || sda_pull);
	twe_target #(.ADDR_W(8), .WR_CYC(WR_CYC)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.scl_clk(scl_clk), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe),
		.chip_select(chip_select), .write_protect(write_protect), .standby(standby),
		.busy(busy));
	twe_host_model host_u (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda_i(sda_wire));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = !clk_sys;
	end
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Busy run length is measured here so polling may overlap it
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		busy_run <= (busy === 1'b1) ? busy_run + 1 : 0;
		if (busy !== 1'b1 && busy_run != 0) busy_len <= busy_run;
		if (cycles == 20000) begin
			num_errors = num_errors + 1;
			give_verdict();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [7:0] dev(input logic rw);
		return {twe_pkg::TWE_DEV_PREFIX, SEL, rw};
	endfunction
	task automatic send(input logic [7:0] b, input logic ack_exp, input string what);
		logic [7:0] rx;
		logic nine;
		host_u.xfer(b, 1'b1, rx, nine);
		chk(what, {7'h0, !ack_exp}, {7'h0, nine});
	endtask
	task automatic recv(input logic [7:0] exp, input logic last);
		logic [7:0] rx;
		logic nine;
		host_u.xfer(8'hff, last, rx, nine);
		chk("read byte", exp, rx);
	endtask
	task automatic rand_rd(input logic [7:0] a);
		host_u.start();
		send(dev(1'b0), 1'b1, "addr w");
		send(a, 1'b1, "word addr");
		host_u.start();
		send(dev(1'b1), 1'b1, "addr r");
	endtask
	task automatic t_program(input logic want);
		int n;
		n = 0;
		repeat (10) @(posedge clk_sys);
		#1;
		chk("busy", {7'h0, want}, {7'h0, busy});
		chk("standby", {7'h0, !want}, {7'h0, standby});
		if (want) begin
			host_u.start();
			send(dev(1'b0), 1'b0, "poll");
			host_u.stop();
			while (busy === 1'b1 && n < 1000) begin
				@(posedge clk_sys);
				#1;
				n++;
			end
			@(posedge clk_sys);
			#1;
			chk("busy length", 8'(WR_CYC), busy_len[7:0]);
			chk("standby end", 8'h1, {7'h0, standby});
		end
	endtask
	task automatic t_reset();
		logic stuck;
		chk("standby rst", 8'h1, {7'h0, standby});
		chk("busy rst", 8'h0, {7'h0, busy});
		chk("oe rst", 8'h0, {7'h0, sda_oe});
		chk("sda_o", 8'h0, {7'h0, sda_o});
		host_u.recover(stuck);
		chk("stuck", 8'h0, {7'h0, stuck});
		host_u.stop();
	endtask
	// Ten bytes from offset 6 wrap round inside the first 8-byte page
	task automatic t_page();
		host_u.start();
		send(dev(1'b0), 1'b1, "addr w");
		send(8'h06, 1'b1, "word addr");
		for (int i = 0; i < 10; i++) begin
			send(8'h30 + 8'(i), 1'b1, "data");
		end
		host_u.stop();
		t_program(1'b1);
		rand_rd(8'h00);
		for (int k = 0; k < 8; k++) begin
			recv(8'h32 + 8'(k), 1'b0);
		end
		recv(twe_pkg::TWE_MEM_RST, 1'b1);
		host_u.stop();
		repeat (10) @(posedge clk_sys);
		#1;
		chk("standby rd", 8'h1, {7'h0, standby});
		rand_rd(8'hff);
		recv(twe_pkg::TWE_MEM_RST, 1'b0);
		recv(8'h32, 1'b1);
		host_u.stop();
	endtask
	task automatic t_select();
		for (int s = 0; s < 8; s++) begin
			host_u.start();
			send({twe_pkg::TWE_DEV_PREFIX, 3'(s), 1'b0}, 3'(s) == SEL, "select");
			host_u.stop();
		end
		host_u.start();
		send({4'hb, SEL, 1'b0}, 1'b0, "prefix");
		host_u.stop();
	endtask
	task automatic t_wp();
		@(posedge clk_sys);
		write_protect <= 1'b1;
		repeat (4) @(posedge clk_sys);
		host_u.start();
		send(dev(1'b0), 1'b1, "wp addr");
		send(8'h00, 1'b1, "wp word");
		send(8'h77, 1'b1, "wp data");
		host_u.stop();
		t_program(1'b0);
		rand_rd(8'h00);
		recv(8'h32, 1'b1);
		host_u.stop();
		host_u.start();
		send(dev(1'b1), 1'b1, "cur addr");
		recv(8'h33, 1'b1);
		host_u.stop();
		@(posedge clk_sys);
		write_protect <= 1'b0;
	endtask
	// One byte into the first page must leave its neighbours alone
	task automatic t_partial();
		host_u.start();
		send(dev(1'b0), 1'b1, "pp addr");
		send(8'h05, 1'b1, "pp word");
		send(8'h5a, 1'b1, "pp data");
		host_u.stop();
		t_program(1'b1);
		rand_rd(8'h04);
		recv(8'h36, 1'b0);
		recv(8'h5a, 1'b0);
		recv(8'h38, 1'b1);
		host_u.stop();
	endtask
	initial begin
		rst = 1'b1;
		chip_select = twe_pkg::twe_sel_t'(SEL);
		write_protect = 1'b0;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (5) @(posedge clk_sys);
		#3;
		t_reset();
		t_page();
		t_select();
		t_wp();
		t_partial();
		give_verdict();
	end
endmodule
`default_nettype wire
